// [bench/sdrw_checker.sv]
// checker for the ring walker memory and hand-off ports
`timescale 1ns/1ps
module sdrw_checker (
  input wire logic        pclk, presetn, mem_req, mem_we, mem_ack, xfer_valid, xfer_done, xfer_ovf,
  input wire logic [31:0] mem_addr, mem_wdata, mem_rdata, xfer_ptr,
  input wire logic [15:0] xfer_len, xfer_count,
  input wire logic [1:0]  xfer_ring,
  input wire logic        xfer_last, xfer_local, xfer_swap
);
  logic        ph;          // word 1 expected next
  logic [31:0] b, w0, w1;   // last descriptor address and words
  logic [1:0]  rg;          // ring of the finished buffer
  logic [15:0] cn;          // count of the finished buffer
  logic        ov;          // overflow of the finished buffer
  wire rd = mem_req && !mem_we;
  wire wb = mem_req && mem_we;
  wire a1 = rd && mem_ack && ph;
  // shadow of the descriptor pair, so write-backs can be judged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ph, b, w0, w1, rg, cn, ov} <= '0;
    end else begin
      if (rd && mem_ack) begin
        ph <= !ph;
        if (ph) w1 <= mem_rdata;
        else {b, w0} <= {mem_addr, mem_rdata};
      end
      if (xfer_valid && xfer_done) {rg, cn, ov} <= {xfer_ring, xfer_count, xfer_ovf};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence quiet3;
    (!xfer_valid && !wb)[*3];
  endsequence
  own_clear_a: assert property (wb && !w0[24] |-> !mem_wdata[31])
    else $error("ownership left set");
  keep_own_a: assert property (wb && w0[24] |-> mem_wdata[31])
    else $error("ownership cleared");
  not_ready_a: assert property (a1 && !(w0[31] && (w0[30] || w0[15:0] != 16'h0)) |=> quiet3)
    else $error("idle descriptor used");
  jump_skip_a: assert property (a1 && w0[31] && w0[30] |=> quiet3)
    else $error("jump moved data");
  word1_addr_a: assert property (rd && ph |-> mem_addr == b + 32'h4)
    else $error("word 1 address wrong");
  hand_off_a: assert property ($rose(xfer_valid) |-> xfer_ptr == w1 && xfer_len == w0[15:0]
    && xfer_last == w0[29] && xfer_local == w0[22]) else $error("hand-off fields wrong");
  swap_sel_a: assert property ($rose(xfer_valid) && !w0[22] |-> xfer_swap == w0[21])
    else $error("swap wrong");
  out_len_a: assert property (wb && rg[1] |-> mem_wdata[15:0] == cn && (mem_wdata[27] || !ov))
    else $error("output write-back wrong");
  done_wb_a: assert property (xfer_valid && xfer_done |=> wb && mem_addr == b)
    else $error("no write-back");
endmodule : sdrw_checker
bind sdrw_ring_walker sdrw_checker sdrw_checker_i (.pclk, .presetn, .mem_req, .mem_we, .mem_ack, .xfer_valid,
  .xfer_done, .xfer_ovf, .mem_addr, .mem_wdata, .mem_rdata, .xfer_ptr, .xfer_len, .xfer_count, .xfer_ring,
  .xfer_last, .xfer_local, .xfer_swap);

// [bench/sdrw_mem_model.sv]
// shared memory holding the rings that software builds
`timescale 1ns/1ps
module sdrw_mem_model (
  input wire logic        pclk, presetn, mem_req, mem_we, slow,
  input wire logic [31:0] mem_addr, mem_wdata,
  output logic            mem_ack,
  output logic [31:0]     mem_rdata
);
  logic [31:0] m [0:255];  // word store, loaded by the bench
  logic [1:0]  w;          // stall count in slow mode
  // data bus shows junk outside an answer so stale reads are caught
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {mem_ack, mem_rdata, w} <= '0;
    end else begin
      mem_ack <= 1'b0;
      if (mem_req && !mem_ack && (!slow || w == 2'h3)) begin
        mem_ack <= 1'b1;
        w <= 2'h0;
        if (mem_we) m[mem_addr[9:2]] <= mem_wdata;
        else mem_rdata <= m[mem_addr[9:2]];
      end else begin
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack) w <= w + 2'h1;
      end
    end
  end
endmodule : sdrw_mem_model

// [bench/testbench.sv]
// self-checking bench for the descriptor ring walker
`timescale 1ns/1ps
module testbench;
  import sdrw_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, dst_demand, res_demand, xfer_done, xfer_ovf, slow, e;
  logic pready, pslverr, mem_req, mem_we, mem_ack, xfer_valid, xfer_last, xfer_local, xfer_swap;
  logic [31:0] pwdata, prdata, mem_rdata, mem_addr, mem_wdata, xfer_ptr, r;
  logic [15:0] xfer_len, xfer_count;
  logic [7:0]  paddr;
  logic [1:0]  xfer_ring;
  int n_errors = 0, checked = 0, cyc = 0;
  sdrw_ring_walker sdrw_ring_walker_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .dst_demand,
    .res_demand, .xfer_valid, .xfer_ring, .xfer_ptr, .xfer_len, .xfer_last, .xfer_local, .xfer_swap,
    .xfer_done, .xfer_count, .xfer_ovf);
  sdrw_mem_model sdrw_mem_model_i (.pclk, .presetn, .mem_req, .mem_we, .slow, .mem_addr, .mem_wdata,
    .mem_ack, .mem_rdata);
  initial begin pclk = 1'b0; forever #12.5 pclk = ~pclk; end
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge pclk) begin cyc++; if (cyc == 20000) begin n_errors++; summarize(); end end
  task check(input logic [31:0] s, x);
    checked++;
    if (s !== x) begin n_errors++; $display("mismatch at %0t: seen %h expected %h", $time, s, x); end
  endtask : check
  task summarize();
    $display("checked %0d, errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk); {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge pclk); penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata; e = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb
  // act as the pipeline: take one buffer, finish it, let write-back land
  task serve(input logic [1:0] rg, input logic [31:0] p, input logic [15:0] c, input logic o, input logic [1:0] ls);
    while (xfer_valid !== 1'b1) @(posedge pclk);
    check(xfer_ring, rg);
    check({xfer_local, xfer_swap}, ls);
    check(xfer_ptr, p);
    {xfer_count, xfer_ovf, xfer_done} <= {c, o, 1'b1};
    @(posedge pclk); xfer_done <= 1'b0;
    repeat (20) @(posedge pclk);
  endtask : serve
  logic [31:0] ra [4] = '{32'h100, 32'h200, 32'h380, 32'h300};
  task regs_test();
    apb(1'b0, OFS_POLL, 32'h0); check(r, {16'h0, POLL_RESET});
    apb(1'b1, OFS_POLL, 32'h4);
    apb(1'b0, 8'h20, 32'h0); check(r, 32'h0); check({31'h0, e}, 32'h1);
    foreach (ra[i]) apb(1'b1, 8'(4 * i), ra[i]);
  endtask : regs_test
  // command, then a source that is owned but empty until software fills it
  task cmd_src_test();
    sdrw_mem_model_i.m[8'h41] = 32'h1000; sdrw_mem_model_i.m[8'h40] = 32'ha060_0010;
    sdrw_mem_model_i.m[8'h80] = 32'h8000_0000;
    apb(1'b1, OFS_CTRL, 32'haa);
    serve(RING_CMD, 32'h1000, 16'h0, 1'b0, 2'h2);
    repeat (40) @(posedge pclk);
    check(xfer_valid, 1'b0);
    sdrw_mem_model_i.m[8'h81] = 32'h2000; sdrw_mem_model_i.m[8'h80] = 32'ha3a0_0008;
    serve(RING_SRC, 32'h2000, 16'h0, 1'b0, 2'h1);
    check(sdrw_mem_model_i.m[8'h40], 32'h2060_0010);
    check(sdrw_mem_model_i.m[8'h80], 32'ha3a0_0008);
    apb(1'b0, OFS_CMD_ADDR, 32'h0); check(r, 32'h108);
    apb(1'b0, OFS_SRC_ADDR, 32'h0); check(r, 32'h220);
    apb(1'b0, OFS_CTRL, 32'h0); check(r[11:8], 4'h1);
  endtask : cmd_src_test
  // jump in the destination ring, overflow carried into the result
  task out_test();
    slow <= 1'b1;
    sdrw_mem_model_i.m[8'hc1] = 32'h340; sdrw_mem_model_i.m[8'hc0] = 32'hc000_0000;
    sdrw_mem_model_i.m[8'hd1] = 32'h3000; sdrw_mem_model_i.m[8'hd0] = 32'ha000_0040;
    sdrw_mem_model_i.m[8'he1] = 32'h4000; sdrw_mem_model_i.m[8'he0] = 32'ha000_0020;
    dst_demand <= 1'b1;
    serve(RING_DST, 32'h3000, 16'h40, 1'b1, 2'h0);
    {dst_demand, res_demand} <= 2'h1;
    serve(RING_RES, 32'h4000, 16'hc, 1'b0, 2'h0);
    res_demand <= 1'b0;
    check(sdrw_mem_model_i.m[8'hd0], 32'h2800_0040);
    check(sdrw_mem_model_i.m[8'he0], 32'h2c00_000c);
    apb(1'b0, OFS_DST_ADDR, 32'h0); check(r, 32'h348);
    apb(1'b0, OFS_CTRL, 32'h0); check(r[11:8], 4'hd);
  endtask : out_test
  initial begin
    {psel, penable, pwrite, paddr, pwdata, dst_demand, res_demand} = '0;
    {xfer_done, xfer_count, xfer_ovf, slow, presetn} = '0;
    for (int i = 0; i < 256; i++) sdrw_mem_model_i.m[i] = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    regs_test();
    cmd_src_test();
    out_test();
    summarize();
  end
endmodule : testbench

// [pkg/sdrw_pkg.sv]
// constants, register map and types for the descriptor ring walker
// Operation
// - clear ownership bit 31 when finished
// - zero length without jump means not ready
// - re-poll not-ready descriptor at intervals
// - jump loads word 1 into ring address
// - bit 29 marks final fragment
// - bit 25 masks ring done flag
// - bit 24 keeps ownership bit set
// - bit 23 strides 32 bytes, else 8
// - bit 22 selects local cpu address space
// - bit 21 swaps bytes, pci space only; code also swaps local space outside the on-chip window
// - word 1 is full 32-bit pointer
// - output descriptors get command overflow bit 27
// - result bit 26 copies destination overflow
// - output length overwritten with bytes written
// - one source per command; outputs on demand
// - inputs any alignment, outputs word aligned
package sdrw_pkg;

  // ***********************************************************
  // ring numbering
  // ***********************************************************
  localparam logic [1:0] RING_CMD = 2'h0;   // command ring
  localparam logic [1:0] RING_SRC = 2'h1;   // source data ring
  localparam logic [1:0] RING_RES = 2'h2;   // result ring
  localparam logic [1:0] RING_DST = 2'h3;   // destination ring

  // ***********************************************************
  // descriptor word 0 fields
  // ***********************************************************
  localparam int OWN_BIT     = 31;          // owned by engine
  localparam int JUMP_BIT    = 30;          // word 1 is next descriptor
  localparam int LAST_BIT    = 29;          // final fragment
  localparam int OVF_BIT     = 27;          // command overflowed
  localparam int DST_OVF_BIT = 26;          // destination overflowed
  localparam int MASK_BIT    = 25;          // suppress done flag
  localparam int KEEP_BIT    = 24;          // keep_owned_flag
  localparam int WIDE_BIT    = 23;          // wide_stride
  localparam int LOCAL_BIT   = 22;          // local_cpu_pointer
  localparam int SWAP_BIT    = 21;          // swap_byte_order
  localparam int LEN_W       = 16;          // length field width

  // ***********************************************************
  // strides and alignment
  // ***********************************************************
  localparam logic [31:0] STRIDE_NARROW = 32'h0000_0008;
  localparam logic [31:0] STRIDE_WIDE   = 32'h0000_0020;
  localparam logic [31:0] WORD_MASK     = 32'hffff_fffc;
  localparam logic [31:0] WORD_STEP     = 32'h0000_0004;

  // ***********************************************************
  // apb register map
  // ***********************************************************
  localparam logic [7:0] OFS_CMD_ADDR = 8'h00;   // command ring address
  localparam logic [7:0] OFS_SRC_ADDR = 8'h04;   // source ring address
  localparam logic [7:0] OFS_RES_ADDR = 8'h08;   // result ring address
  localparam logic [7:0] OFS_DST_ADDR = 8'h0c;   // destination ring address
  localparam logic [7:0] OFS_CTRL     = 8'h10;   // ring control / done flags
  localparam logic [7:0] OFS_POLL     = 8'h14;   // poll interval in cycles
  localparam int CTRL_EN_LSB   = 0;              // 4 x 2-bit ring control
  localparam int CTRL_DONE_LSB = 8;              // 4 done flags, write 1 clear
  localparam int CTRL_OWED_BIT = 12;             // source descriptor owed
  localparam int CTRL_BUSY_BIT = 13;             // walker not idle
  localparam logic [1:0]  RING_EN_CODE = 2'h2;   // enable code 0b10
  localparam logic [15:0] POLL_RESET   = 16'h0040;

  // ***********************************************************
  // walker states
  // ***********************************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_RD0, ST_RD1, ST_EVAL, ST_XFER, ST_WB, ST_NEXT
  } sdrw_state_t;

endpackage : sdrw_pkg

// [rtl/sdrw_desc_fields.sv]
// descriptor word 0 decoding and write-back word construction
`timescale 1ns/1ps
module sdrw_desc_fields (
  input  wire logic [31:0] word0,       // fetched word 0
  input  wire logic [1:0]  ring,        // ring the word came from
  input  wire logic [15:0] count,       // bytes actually written
  input  wire logic        ovf_any,     // command overflowed somewhere
  input  wire logic        dst_ovf,     // a destination overflowed
  output logic             ready,       // descriptor usable
  output logic             jump,        // jump descriptor
  output logic             last,        // final fragment
  output logic             mask_done,   // no done flag
  output logic             wide,        // 32-byte stride
  output logic             local_ptr,   // local cpu space pointer
  output logic             swap,        // byte swap requested
  output logic             out_ring,    // destination or result ring
  output logic [15:0]      len,         // length field
  output logic [31:0]      wb_word      // word 0 to write back
);
  import sdrw_pkg::*;

  // ***********************************************************
  // field decode
  // ***********************************************************
  always_comb begin
    jump      = word0[JUMP_BIT];
    last      = word0[LAST_BIT];
    mask_done = word0[MASK_BIT];
    wide      = word0[WIDE_BIT];
    local_ptr = word0[LOCAL_BIT];
    swap      = word0[SWAP_BIT];
    len       = word0[LEN_W-1:0];
    out_ring  = (ring == RING_DST) || (ring == RING_RES);
    // owned but zero length is still a buffer being filled in
    ready     = word0[OWN_BIT] && (jump || (len != 16'h0000));
  end

  // ***********************************************************
  // write-back word
  // ***********************************************************
  always_comb begin
    wb_word = word0;
    if (!word0[KEEP_BIT]) begin
      wb_word[OWN_BIT] = 1'b0;
    end
    if (out_ring) begin
      wb_word[LEN_W-1:0] = count;
      if (ovf_any) begin
        wb_word[OVF_BIT] = 1'b1;
      end
    end
    if (ring == RING_RES) begin
      wb_word[DST_OVF_BIT] = dst_ovf;
    end
  end

endmodule : sdrw_desc_fields

// [rtl/sdrw_ring_walker.sv]
// four-ring descriptor walker with apb register slave
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
module sdrw_ring_walker #(
  parameter logic [31:0] ONCHIP_BASE = 32'h0000_0000,   // on-chip ram window base
  parameter logic [31:0] ONCHIP_MASK = 32'hffff_0000    // window compare mask
) (
  input  wire logic        pclk,          // core clock, 40 MHz
  input  wire logic        presetn,       // async reset, active low
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb access phase
  input  wire logic        pwrite,        // apb direction
  input  wire logic [7:0]  paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic [31:0]      prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error, unmapped address
  output logic             mem_req,       // memory request, held to ack
  output logic             mem_we,        // memory write
  output logic [31:0]      mem_addr,      // memory byte address
  output logic [31:0]      mem_wdata,     // memory write data
  input  wire logic        mem_ack,       // memory beat done
  input  wire logic [31:0] mem_rdata,     // memory read data
  input  wire logic        dst_demand,    // pipeline needs destination space
  input  wire logic        res_demand,    // pipeline needs result space
  output logic             xfer_valid,    // buffer handed to pipeline
  output logic [1:0]       xfer_ring,     // ring of the buffer
  output logic [31:0]      xfer_ptr,      // buffer byte pointer
  output logic [15:0]      xfer_len,      // buffer length or capacity
  output logic             xfer_last,     // final fragment
  output logic             xfer_local,    // pointer is local cpu space
  output logic             xfer_swap,     // swap bytes while moving
  input  wire logic        xfer_done,     // pipeline finished buffer
  input  wire logic [15:0] xfer_count,    // bytes written to output buffer
  input  wire logic        xfer_ovf       // buffer overflowed
);
  import sdrw_pkg::*;

  // refuse a window whose base has bits the compare would drop
  if ((ONCHIP_MASK & ONCHIP_BASE) != ONCHIP_BASE) begin : g_bad_window
    $error("onchip base has bits outside its mask");
  end

  // ***********************************************************
  // state
  // ***********************************************************
  logic [31:0] ring_addr [4];     // next descriptor per ring
  logic [15:0] poll_cnt  [4];     // re-poll wait per ring
  logic [15:0] poll_gap;          // software poll interval
  logic [7:0]  ring_ctrl;         // 2-bit control per ring
  logic [3:0]  done_flag;         // sticky ring done flags
  logic        src_owed;          // command needs its source descriptor
  logic        ovf_any;           // overflow seen in current command
  logic        dst_ovf;           // destination overflow in current command
  sdrw_state_t state;             // walker state
  logic [1:0]  cur;               // ring being serviced
  logic [1:0]  last_pick;         // round-robin memory
  logic [31:0] w0;                // fetched word 0
  logic [31:0] w1;                // fetched word 1
  logic [3:0]  elig;              // rings that may be polled
  logic [1:0]  pick;              // chosen ring
  logic        pick_ok;           // a ring is chosen
  logic        apb_wr;            // write access this cycle
  logic        apb_rd;            // read access this cycle
  logic        d_ready;
  logic        d_jump;
  logic        d_last;
  logic        d_mask;
  logic        d_wide;
  logic        d_local;
  logic        d_swap;
  logic        d_out;
  logic [15:0] d_len;
  logic [31:0] d_wb;
  logic [31:0] next_ptr;          // buffer pointer after alignment

  // ***********************************************************
  // helpers
  // ***********************************************************
  // decode used only by the slave error response
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == OFS_CMD_ADDR) || (a == OFS_SRC_ADDR) || (a == OFS_RES_ADDR) ||
                  (a == OFS_DST_ADDR) || (a == OFS_CTRL) || (a == OFS_POLL);
  endfunction : addr_mapped

  // ring address registers sit at consecutive words from zero
  function automatic logic addr_is_ring(input logic [7:0] a, input logic [1:0] r);
    addr_is_ring = (a == {4'h0, r, 2'h0});
  endfunction : addr_is_ring

  // output rings must stay word aligned, input rings keep any byte
  function automatic logic [31:0] align_for(input logic [1:0] r, input logic [31:0] a);
    align_for = ((r == RING_DST) || (r == RING_RES)) ? (a & WORD_MASK) : a;
  endfunction : align_for

  // ***********************************************************
  // descriptor decode
  // ***********************************************************
  sdrw_desc_fields u_fields (
    .word0     (w0),
    .ring      (cur),
    .count     (xfer_count),
    .ovf_any   (ovf_any | xfer_ovf),
    .dst_ovf   (dst_ovf | (xfer_ovf & (cur == RING_DST))),
    .ready     (d_ready),
    .jump      (d_jump),
    .last      (d_last),
    .mask_done (d_mask),
    .wide      (d_wide),
    .local_ptr (d_local),
    .swap      (d_swap),
    .out_ring  (d_out),
    .len       (d_len),
    .wb_word   (d_wb)
  );

  assign next_ptr = align_for(cur, w1);

  // ***********************************************************
  // apb slave
  // ***********************************************************
  assign apb_wr = psel && penable && pwrite && !pready;
  assign apb_rd = psel && penable && !pwrite && !pready;

  // one wait state: ready rises the cycle after access starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_mapped(paddr);
      prdata  <= 32'h0000_0000;
      if (apb_rd) begin
        unique case (paddr)
          OFS_CMD_ADDR: prdata <= ring_addr[RING_CMD];
          OFS_SRC_ADDR: prdata <= ring_addr[RING_SRC];
          OFS_RES_ADDR: prdata <= ring_addr[RING_RES];
          OFS_DST_ADDR: prdata <= ring_addr[RING_DST];
          OFS_POLL:     prdata <= {16'h0000, poll_gap};
          OFS_CTRL: begin
            prdata[CTRL_EN_LSB +: 8]   <= ring_ctrl;
            prdata[CTRL_DONE_LSB +: 4] <= done_flag;
            prdata[CTRL_OWED_BIT]      <= src_owed;
            prdata[CTRL_BUSY_BIT]      <= (state != ST_IDLE);
          end
          default:      prdata <= 32'h0000_0000;   // unmapped reads zero
        endcase
      end
    end
  end

  // ring control and poll interval registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ring_ctrl <= 8'h00;
      poll_gap  <= POLL_RESET;
    end else if (apb_wr) begin
      if (paddr == OFS_CTRL) begin
        ring_ctrl <= pwdata[CTRL_EN_LSB +: 8];
      end
      if (paddr == OFS_POLL) begin
        // a zero gap would spin on memory; keep at least one cycle
        poll_gap <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
      end
    end
  end

  // ***********************************************************
  // ring address registers
  // ***********************************************************
  // hardware update wins over a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        ring_addr[i] <= 32'h0000_0000;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if ((state == ST_EVAL) && (cur == 2'(i)) && d_ready && d_jump) begin
          ring_addr[i] <= next_ptr;
        end else if ((state == ST_NEXT) && (cur == 2'(i))) begin
          ring_addr[i] <= ring_addr[i] + (d_wide ? STRIDE_WIDE : STRIDE_NARROW);
        end else if (apb_wr && addr_is_ring(paddr, 2'(i))) begin
          ring_addr[i] <= align_for(2'(i), pwdata);
        end
      end
    end
  end

  // ***********************************************************
  // polling timers
  // ***********************************************************
  // a not-ready ring sleeps for the poll gap, then is read again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        poll_cnt[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if ((state == ST_EVAL) && (cur == 2'(i)) && !d_ready) begin
          poll_cnt[i] <= poll_gap;
        end else if (poll_cnt[i] != 16'h0000) begin
          poll_cnt[i] <= poll_cnt[i] - 16'h0001;
        end
      end
    end
  end

  // ***********************************************************
  // ring eligibility and round-robin pick
  // ***********************************************************
  // source only after a command, outputs only when the pipeline asks
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      elig[i] = (ring_ctrl[2*i +: 2] == RING_EN_CODE) && (poll_cnt[i] == 16'h0000);
    end
    elig[RING_CMD] = elig[RING_CMD] && !src_owed;
    elig[RING_SRC] = elig[RING_SRC] && src_owed;
    elig[RING_RES] = elig[RING_RES] && res_demand;
    elig[RING_DST] = elig[RING_DST] && dst_demand;
    pick    = last_pick;
    pick_ok = 1'b0;
    for (int k = 4; k >= 1; k--) begin
      if (elig[2'(last_pick + 2'(k))]) begin
        pick    = 2'(last_pick + 2'(k));
        pick_ok = 1'b1;
      end
    end
  end

  // ***********************************************************
  // walker state machine and memory / pipeline ports
  // ***********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= ST_IDLE;
      cur        <= RING_CMD;
      last_pick  <= RING_DST;
      w0         <= 32'h0000_0000;
      w1         <= 32'h0000_0000;
      mem_req    <= 1'b0;
      mem_we     <= 1'b0;
      mem_addr   <= 32'h0000_0000;
      mem_wdata  <= 32'h0000_0000;
      xfer_valid <= 1'b0;
      xfer_ring  <= RING_CMD;
      xfer_ptr   <= 32'h0000_0000;
      xfer_len   <= 16'h0000;
      xfer_last  <= 1'b0;
      xfer_local <= 1'b0;
      xfer_swap  <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (pick_ok) begin
            cur       <= pick;
            last_pick <= pick;
            mem_req   <= 1'b1;
            mem_we    <= 1'b0;
            mem_addr  <= ring_addr[pick];
            state     <= ST_RD0;
          end
        end
        ST_RD0: begin
          if (mem_ack) begin
            w0       <= mem_rdata;
            mem_addr <= mem_addr + WORD_STEP;
            state    <= ST_RD1;
          end
        end
        ST_RD1: begin
          if (mem_ack) begin
            w1      <= mem_rdata;
            mem_req <= 1'b0;
            state   <= ST_EVAL;
          end
        end
        ST_EVAL: begin
          if (!d_ready || d_jump) begin
            state <= ST_IDLE;
          end else begin
            xfer_valid <= 1'b1;
            xfer_ring  <= cur;
            xfer_ptr   <= next_ptr;
            xfer_len   <= d_len;
            xfer_last  <= d_last;
            xfer_local <= d_local;
            // on-chip ram is never swapped; pci space and local space outside the window can be
            xfer_swap  <= d_swap && !(d_local && ((next_ptr & ONCHIP_MASK) == ONCHIP_BASE));
            state      <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (xfer_done) begin
            xfer_valid <= 1'b0;
            mem_req    <= 1'b1;
            mem_we     <= 1'b1;
            mem_addr   <= ring_addr[cur];
            mem_wdata  <= d_wb;
            state      <= ST_WB;
          end
        end
        ST_WB: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we  <= 1'b0;
            state   <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ***********************************************************
  // command bookkeeping
  // ***********************************************************
  // the last command fragment owes one source descriptor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_owed <= 1'b0;
    end else if ((state == ST_NEXT) && d_last) begin
      if (cur == RING_CMD) begin
        src_owed <= 1'b1;
      end else if (cur == RING_SRC) begin
        src_owed <= 1'b0;
      end
    end
  end

  // overflow history lives until the command's last result descriptor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_any <= 1'b0;
      dst_ovf <= 1'b0;
    end else if ((state == ST_XFER) && xfer_done && xfer_ovf) begin
      ovf_any <= 1'b1;
      if (cur == RING_DST) begin
        dst_ovf <= 1'b1;
      end
    end else if ((state == ST_NEXT) && (cur == RING_RES) && d_last) begin
      ovf_any <= 1'b0;
      dst_ovf <= 1'b0;
    end
  end

  // done flags: hardware set beats a software clear in one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_flag <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if ((state == ST_NEXT) && (cur == 2'(i)) && !d_mask) begin
          done_flag[i] <= 1'b1;
        end else if (apb_wr && (paddr == OFS_CTRL) && pwdata[CTRL_DONE_LSB + i]) begin
          done_flag[i] <= 1'b0;
        end
      end
    end
  end

endmodule : sdrw_ring_walker
